/* File: rtl/card_device.sv */
// Card end: identity, condition word, protect groups, bus answers
// Notes on behaviour
// - Capacity shrinks by retiring whole protect groups
// - Writes into retired groups get protect error
// - Host avoids retired reads; device answers error
// - Protect query reports retired groups as permanent
// - One bit per bus clock per line
// - Command line open-drain at init, push-pull later
// - Data lines driven by writer of data
// - Fast mode drives return strobe with data
// - Hardware reset: pre-idle, clears power-on protection
// - Device holds 32-bit operating condition word
// - Condition bit 31 low until power-up done
// - Voltage profile and reserved bits fixed values
// - Access mode field reads 10b
// - Device holds 128-bit identity word
// - Unique 32-bit serial in bits 47:16
// - Identity word field layout as specified
// - Identity word bit 0 reads one
//
// Decided for this implementation: the placing of the registers and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
module card_device #(
	parameter int PWRUP_CYC = 64,
	parameter logic [31:0] SERIAL = 32'hC0DE_0001,
	parameter logic [7:0] BUILD_DATE = 8'h00
) (
	input wire logic hclk,
	input wire logic hresetn,
	card_bus_if.device bus,
	input wire logic retire_stb,
	input wire logic [card_pkg::GRP_W-1:0] retire_grp,
	output logic [card_pkg::GROUPS-1:0] retired,
	output logic pwr_done
);
	// ==========================================
	// Identity word
	function automatic logic [6:0] crc7(input logic [119:0] d);
		logic [6:0] c;
		logic fb;
		c = '0;
		for (int i = 119; i >= 0; i--) begin
			fb = d[i] ^ c[6];
			c = {c[5:0], 1'b0} ^ (fb ? card_pkg::CRC_POLY : 7'h00);
		end
		return c;
	endfunction

	localparam logic [119:0] ID_BODY = {card_pkg::MAKER_CODE, 6'h00, card_pkg::PACKAGE_BGA,
		card_pkg::APP_CODE, card_pkg::PRODUCT_LABEL, card_pkg::PRODUCT_REV, SERIAL, BUILD_DATE};
	localparam logic [127:0] ID_WORD = {ID_BODY, crc7(ID_BODY), 1'b1};

	// ==========================================
	// Pin synchronisers
	logic [10:0] s1_r;
	logic [10:0] s2_r;
	logic clk_d_r;
	logic rise;
	logic cmd_s;
	logic [7:0] dat_s;
	logic rst_s;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= '0;
			s2_r <= '0;
			clk_d_r <= 1'b0;
		end else begin
			s1_r <= {bus.rst_n, bus.dat, bus.cmd, bus.bus_clk};
			s2_r <= s1_r;
			clk_d_r <= s2_r[0];
		end
	end

	// One bit moved per bus clock rise
	assign rise = s2_r[0] & ~clk_d_r;
	assign cmd_s = s2_r[1];
	assign dat_s = s2_r[9:2];
	assign rst_s = s2_r[10];

	// ==========================================
	// Power-up routine
	logic [15:0] pwr_cnt_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pwr_cnt_r <= '0;
		end else if (!rst_s) begin
			pwr_cnt_r <= '0;
		end else if (!pwr_done) begin
			pwr_cnt_r <= pwr_cnt_r + 16'h0001;
		end
	end

	assign pwr_done = (pwr_cnt_r == 16'(PWRUP_CYC));

	logic [31:0] cond_word;
	assign cond_word = {pwr_done, card_pkg::ACCESS_MODE, 5'h00, card_pkg::VOLT_HIGH,
		card_pkg::VOLT_MID, card_pkg::VOLT_LOW, 7'h00};

	// ==========================================
	// Command decode
	card_pkg::dev_state_t state_r;
	logic [7:0] cnt_r;
	logic [39:0] rx_r;
	logic [127:0] tx_r;
	logic [7:0] len_r;
	logic drv_r;
	logic bit_r;
	logic pp_r;
	logic hs_r;
	logic [7:0] dat_oe_r;
	logic [7:0] dat_out_r;
	logic strobe_r;
	logic [7:0] mem_r [2**card_pkg::MEM_AW];
	logic [card_pkg::GROUPS-1:0] retired_r;
	logic [card_pkg::GROUPS-1:0] pon_r;
	logic exec;
	logic [7:0] op;
	logic [card_pkg::MEM_AW-1:0] addr;
	logic [card_pkg::GRP_W-1:0] grp;
	logic ret_hit;
	logic pon_hit;
	logic [31:0] stat;
	logic [127:0] resp_nxt;
	logic [7:0] len_nxt;
	logic wr_ok;
	logic rd_ok;

	assign exec = rise && state_r == card_pkg::D_RX && cnt_r == card_pkg::FRAME_BITS;
	assign op = rx_r[39:32];
	assign addr = rx_r[card_pkg::MEM_AW-1:0];
	assign grp = addr[card_pkg::MEM_AW-1:1];
	assign ret_hit = retired_r[grp];
	assign pon_hit = pon_r[grp];

	always_comb begin
		stat = '0;
		len_nxt = card_pkg::RESP_SHORT;
		wr_ok = 1'b0;
		rd_ok = 1'b0;
		resp_nxt = '0;
		// Words come from constants plus the power-up flag in bit 31, no op alters them
		unique case (op)
			card_pkg::OP_GET_COND: begin
				stat = cond_word;
			end
			card_pkg::OP_GET_ID: begin
				len_nxt = card_pkg::RESP_LONG;
			end
			card_pkg::OP_WRITE: begin
				wr_ok = !ret_hit && !pon_hit;
				stat[card_pkg::ST_WP_ERR] = !wr_ok;
				stat[card_pkg::ST_OK] = wr_ok;
			end
			card_pkg::OP_READ: begin
				rd_ok = !ret_hit;
				stat[card_pkg::ST_RD_ERR] = ret_hit;
				stat[card_pkg::ST_OK] = rd_ok;
			end
			card_pkg::OP_PROT: begin
				stat[card_pkg::ST_PROT] = ret_hit | pon_hit;
				stat[2:1] = ret_hit ? card_pkg::PT_PERM : (pon_hit ? card_pkg::PT_PON : card_pkg::PT_NONE);
			end
			card_pkg::OP_PON_WP, card_pkg::OP_SET_BUS: begin
				stat[card_pkg::ST_OK] = 1'b1;
			end
			default: begin
				stat = '0;
			end
		endcase
		resp_nxt = (op == card_pkg::OP_GET_ID) ? ID_WORD : {stat, 96'h0};
	end

	// ==========================================
	// Protect groups and storage
	// Whole groups retired, never cleared by bus
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			retired_r <= '0;
		end else if (retire_stb) begin
			retired_r[retire_grp] <= 1'b1;
		end
	end

	assign retired = retired_r;

	// Power-on protection dropped by hardware reset
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pon_r <= '0;
		end else if (!rst_s) begin
			pon_r <= '0;
		end else if (exec && op == card_pkg::OP_PON_WP) begin
			pon_r[grp] <= 1'b1;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			for (int i = 0; i < 2**card_pkg::MEM_AW; i++) begin
				mem_r[i] <= '0;
			end
		end else if (exec && op == card_pkg::OP_WRITE && wr_ok) begin
			mem_r[addr] <= dat_s;
		end
	end

	// ==========================================
	// Bus mode
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pp_r <= 1'b0;
			hs_r <= 1'b0;
		end else if (!rst_s) begin
			pp_r <= 1'b0;
			hs_r <= 1'b0;
		end else if (exec && op == card_pkg::OP_SET_BUS) begin
			pp_r <= rx_r[card_pkg::BUS_PP];
			hs_r <= rx_r[card_pkg::BUS_HS];
		end
	end

	// ==========================================
	// Link state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= card_pkg::D_IDLE;
			cnt_r <= '0;
			rx_r <= '0;
			tx_r <= '0;
			len_r <= '0;
			drv_r <= 1'b0;
			bit_r <= 1'b1;
			dat_oe_r <= '0;
			dat_out_r <= '0;
			strobe_r <= 1'b0;
		end else if (!rst_s) begin
			state_r <= card_pkg::D_IDLE;
			drv_r <= 1'b0;
			dat_oe_r <= '0;
			strobe_r <= 1'b0;
		end else if (rise) begin
			unique case (state_r)
				card_pkg::D_IDLE: begin
					if (!cmd_s) begin
						state_r <= card_pkg::D_RX;
						cnt_r <= '0;
					end
				end
				card_pkg::D_RX: begin
					if (cnt_r == card_pkg::FRAME_BITS) begin
						// Gap bit: host still owns the line for its stop bit
						state_r <= card_pkg::D_TX;
						cnt_r <= 8'hFF;
						tx_r <= resp_nxt;
						len_r <= len_nxt;
					end else begin
						rx_r <= {rx_r[38:0], cmd_s};
						cnt_r <= cnt_r + 8'h01;
					end
				end
				card_pkg::D_TX: begin
					dat_oe_r <= '0;
					strobe_r <= 1'b0;
					if (cnt_r == 8'hFF) begin
						drv_r <= 1'b1;
						bit_r <= 1'b0;
						cnt_r <= '0;
						// Card drives data lines on reads outside retired groups
						dat_oe_r <= (op == card_pkg::OP_READ && rd_ok) ? 8'hFF : 8'h00;
						dat_out_r <= mem_r[addr];
						// Strobe marks data cycle in fast mode
						strobe_r <= hs_r && op == card_pkg::OP_READ && rd_ok;
					end else if (cnt_r == len_r) begin
						state_r <= card_pkg::D_IDLE;
						drv_r <= 1'b0;
						bit_r <= 1'b1;
					end else begin
						bit_r <= tx_r[127];
						tx_r <= {tx_r[126:0], 1'b0};
						cnt_r <= cnt_r + 8'h01;
					end
				end
			endcase
		end
	end

	assign bus.d_cmd_oe = drv_r & (pp_r | ~bit_r);
	assign bus.d_cmd_out = pp_r & bit_r;
	assign bus.d_dat_oe = dat_oe_r;
	assign bus.d_dat_out = dat_out_r;
	assign bus.strobe = strobe_r;
endmodule

/* File: rtl/card_pkg.sv */
// Shared constants and types of the card bus host and card ends
package card_pkg;
	// ==========================================
	// Link framing
	localparam logic [7:0] FRAME_BITS = 8'd40;
	localparam logic [7:0] HOST_BITS = 8'd42;
	localparam logic [7:0] RESP_SHORT = 8'd32;
	localparam logic [7:0] RESP_LONG = 8'd128;
	localparam int LINK_PERIOD_NS = 800;
	localparam int HCLK_NS = 100;
	localparam int LINK_HALF_CYC = LINK_PERIOD_NS / (2 * HCLK_NS);
	// ==========================================
	// Commands
	localparam logic [7:0] OP_GET_COND = 8'h01;
	localparam logic [7:0] OP_GET_ID = 8'h02;
	localparam logic [7:0] OP_WRITE = 8'h03;
	localparam logic [7:0] OP_READ = 8'h04;
	localparam logic [7:0] OP_PROT = 8'h05;
	localparam logic [7:0] OP_PON_WP = 8'h06;
	localparam logic [7:0] OP_SET_BUS = 8'h07;
	// ==========================================
	// Answer word fields
	localparam int ST_WP_ERR = 0;
	localparam int ST_RD_ERR = 1;
	localparam int ST_OK = 2;
	localparam int ST_PROT = 0;
	localparam logic [1:0] PT_NONE = 2'h0;
	localparam logic [1:0] PT_PON = 2'h1;
	localparam logic [1:0] PT_PERM = 2'h2;
	localparam int BUS_PP = 0;
	localparam int BUS_HS = 1;
	// ==========================================
	// Storage and protect groups
	localparam int MEM_AW = 4;
	localparam int GRP_W = 3;
	localparam int GROUPS = 8;
	// ==========================================
	// Operating condition word
	localparam logic [1:0] ACCESS_MODE = 2'h2;
	localparam logic [8:0] VOLT_HIGH = 9'h1FF;
	localparam logic [6:0] VOLT_MID = 7'h00;
	localparam logic VOLT_LOW = 1'b1;
	// ==========================================
	// Identity word fields (codes arbitrary)
	localparam logic [7:0] MAKER_CODE = 8'h5A;
	localparam logic [1:0] PACKAGE_BGA = 2'h1;
	localparam logic [7:0] APP_CODE = 8'h3C;
	localparam logic [47:0] PRODUCT_LABEL = 48'h4341_5244_3031;
	localparam logic [7:0] PRODUCT_REV = 8'h10;
	localparam logic [6:0] CRC_POLY = 7'h09;
	// ==========================================
	// Host register map
	localparam logic [7:0] A_OP = 8'h00;
	localparam logic [7:0] A_ARG = 8'h04;
	localparam logic [7:0] A_GO = 8'h08;
	localparam logic [7:0] A_WDATA = 8'h0C;
	localparam logic [7:0] A_STATUS = 8'h10;
	localparam logic [7:0] A_RESP0 = 8'h14;
	localparam logic [7:0] A_RESP1 = 8'h18;
	localparam logic [7:0] A_RESP2 = 8'h1C;
	localparam logic [7:0] A_RESP3 = 8'h20;
	localparam logic [7:0] A_RDATA = 8'h24;
	localparam logic [7:0] A_BUSCFG = 8'h28;
	localparam int CFG_PP = 0;
	localparam int CFG_HWRST = 1;
	localparam int STS_BUSY = 0;
	localparam int STS_DONE = 1;
	// ==========================================
	// State machines
	typedef enum logic [2:0] {D_IDLE = 3'b001, D_RX = 3'b010, D_TX = 3'b100} dev_state_t;
	typedef enum logic [3:0] {H_IDLE = 4'b0001, H_SEND = 4'b0010, H_WAIT = 4'b0100, H_RECV = 4'b1000} host_state_t;
endpackage

/* File: rtl/card_bus_if.sv */
// Card bus wires between host controller and card
`timescale 1ns/1ps
interface card_bus_if;
	logic bus_clk;
	logic rst_n;
	logic strobe;
	logic h_cmd_out;
	logic h_cmd_oe;
	logic d_cmd_out;
	logic d_cmd_oe;
	logic [7:0] h_dat_out;
	logic [7:0] h_dat_oe;
	logic [7:0] d_dat_out;
	logic [7:0] d_dat_oe;
	logic cmd;
	logic [7:0] dat;
	// ==========================================
	// Pulled-up wired lines
	assign cmd = ~((h_cmd_oe & ~h_cmd_out) | (d_cmd_oe & ~d_cmd_out));
	assign dat = ~((h_dat_oe & ~h_dat_out) | (d_dat_oe & ~d_dat_out));
	modport host(output bus_clk, rst_n, h_cmd_out, h_cmd_oe, h_dat_out, h_dat_oe, input cmd, dat);
	modport device(input bus_clk, rst_n, cmd, dat, output d_cmd_out, d_cmd_oe, d_dat_out, d_dat_oe, strobe);
endinterface

/* File: rtl/card_host.sv */
// Host controller end: AHB-Lite registers, link clock, frames
`timescale 1ns/1ps
module card_host #(
	parameter int HALF_CYC = card_pkg::LINK_HALF_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	card_bus_if.host bus
);
	// ==========================================
	// Registers and bus slave
	logic [7:0] op_r;
	logic [31:0] arg_r;
	logic [7:0] wdata_r;
	logic [7:0] rdata_r;
	logic [127:0] resp_r;
	logic [1:0] cfg_r;
	logic busy_r;
	logic done_r;
	logic wr_pend_r;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r;
	logic req;
	logic go;
	logic fin;
	logic [31:0] rd_mux;
	card_pkg::host_state_t state_r;

	assign req = hsel & hready & htrans[1];
	assign go = wr_pend_r && addr_r == card_pkg::A_GO && !busy_r;
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	always_comb begin
		unique case (haddr[7:0])
			card_pkg::A_OP: rd_mux = {24'h0, op_r};
			card_pkg::A_ARG: rd_mux = arg_r;
			card_pkg::A_WDATA: rd_mux = {24'h0, wdata_r};
			card_pkg::A_STATUS: rd_mux = {30'h0, done_r, busy_r};
			card_pkg::A_RESP0: rd_mux = resp_r[31:0];
			card_pkg::A_RESP1: rd_mux = resp_r[63:32];
			card_pkg::A_RESP2: rd_mux = resp_r[95:64];
			card_pkg::A_RESP3: rd_mux = resp_r[127:96];
			card_pkg::A_RDATA: rd_mux = {24'h0, rdata_r};
			card_pkg::A_BUSCFG: rd_mux = {30'h0, cfg_r};
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			addr_r <= '0;
			hrdata_r <= '0;
		end else begin
			wr_pend_r <= req & hwrite;
			if (req) begin
				addr_r <= haddr[7:0];
			end
			if (req && !hwrite) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			op_r <= '0;
			arg_r <= '0;
			wdata_r <= '0;
			cfg_r <= '0;
		end else if (wr_pend_r && !busy_r) begin
			unique case (addr_r)
				card_pkg::A_OP: op_r <= hwdata[7:0];
				card_pkg::A_ARG: arg_r <= hwdata;
				card_pkg::A_WDATA: wdata_r <= hwdata[7:0];
				card_pkg::A_BUSCFG: cfg_r <= hwdata[1:0];
				default: ;
			endcase
		end
	end

	// Done is sticky; completion never meets a start
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			busy_r <= 1'b0;
			done_r <= 1'b0;
		end else if (go) begin
			busy_r <= 1'b1;
			done_r <= 1'b0;
		end else if (fin) begin
			busy_r <= 1'b0;
			done_r <= 1'b1;
		end
	end

	assign bus.rst_n = ~cfg_r[card_pkg::CFG_HWRST];

	// ==========================================
	// Link clock divider
	logic [7:0] div_r;
	logic clk_r;
	logic wrap;
	logic rise_ev;
	logic fall_ev;

	assign wrap = (div_r == 8'(HALF_CYC - 1));
	assign rise_ev = wrap & ~clk_r;
	assign fall_ev = wrap & clk_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			div_r <= '0;
			clk_r <= 1'b0;
		end else if (wrap) begin
			div_r <= '0;
			clk_r <= ~clk_r;
		end else begin
			div_r <= div_r + 8'h01;
		end
	end

	assign bus.bus_clk = clk_r;

	// ==========================================
	// Input synchronisers
	logic [8:0] s1_r;
	logic [8:0] s2_r;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			s1_r <= '1;
			s2_r <= '1;
		end else begin
			s1_r <= {bus.dat, bus.cmd};
			s2_r <= s1_r;
		end
	end

	// ==========================================
	// Frame engine
	logic [41:0] tx_r;
	logic [7:0] cnt_r;
	logic drv_r;
	logic bit_r;
	logic [7:0] dat_oe_r;
	logic [7:0] dat_out_r;
	logic [7:0] len;

	assign len = (op_r == card_pkg::OP_GET_ID) ? card_pkg::RESP_LONG : card_pkg::RESP_SHORT;
	assign fin = rise_ev && state_r == card_pkg::H_RECV && cnt_r == len - 8'h01;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_r <= card_pkg::H_IDLE;
			tx_r <= '0;
			cnt_r <= '0;
			drv_r <= 1'b0;
			bit_r <= 1'b1;
			dat_oe_r <= '0;
			dat_out_r <= '0;
			resp_r <= '0;
			rdata_r <= '0;
		end else begin
			unique case (state_r)
				card_pkg::H_IDLE: begin
					if (go) begin
						state_r <= card_pkg::H_SEND;
						tx_r <= {1'b0, op_r, arg_r, 1'b1};
						cnt_r <= '0;
						resp_r <= '0;
					end
				end
				card_pkg::H_SEND: begin
					// One bit per link clock fall
					if (fall_ev) begin
						if (cnt_r == card_pkg::HOST_BITS) begin
							state_r <= card_pkg::H_WAIT;
							drv_r <= 1'b0;
							bit_r <= 1'b1;
							dat_oe_r <= '0;
						end else begin
							drv_r <= 1'b1;
							bit_r <= tx_r[41];
							tx_r <= {tx_r[40:0], 1'b0};
							cnt_r <= cnt_r + 8'h01;
							// Host drives data with stop bit of writes
							if (op_r == card_pkg::OP_WRITE && cnt_r == card_pkg::HOST_BITS - 8'h01) begin
								dat_oe_r <= 8'hFF;
								dat_out_r <= wdata_r;
							end
						end
					end
				end
				card_pkg::H_WAIT: begin
					if (rise_ev && !s2_r[0]) begin
						state_r <= card_pkg::H_RECV;
						cnt_r <= '0;
						if (op_r == card_pkg::OP_READ) begin
							rdata_r <= s2_r[8:1];
						end
					end
				end
				card_pkg::H_RECV: begin
					// Read error lands in answer word
					if (rise_ev) begin
						resp_r <= {resp_r[126:0], s2_r[0]};
						cnt_r <= cnt_r + 8'h01;
						if (fin) begin
							state_r <= card_pkg::H_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign bus.h_cmd_oe = drv_r & (cfg_r[card_pkg::CFG_PP] | ~bit_r);
	assign bus.h_cmd_out = cfg_r[card_pkg::CFG_PP] & bit_r;
	assign bus.h_dat_oe = dat_oe_r;
	assign bus.h_dat_out = dat_out_r;
endmodule

/* File: verification/card_bus_monitor.sv */
// Wire-level checks on the card bus between host controller and card
`timescale 1ns/1ps
module card_bus_monitor (
	input logic hclk,
	input logic hresetn,
	input logic bus_clk,
	input logic rst_n,
	input logic strobe,
	input logic h_cmd_out,
	input logic h_cmd_oe,
	input logic d_cmd_out,
	input logic d_cmd_oe,
	input logic [7:0] h_dat_oe,
	input logic [7:0] d_dat_oe
);
	default clocking cb @(posedge hclk);
	endclocking
	default disable iff (!hresetn);
	// ==========
	// Link clock and bit timing
	sequence s_hi;
		bus_clk [*4] ##1 !bus_clk;
	endsequence
	sequence s_lo;
		!bus_clk [*4];
	endsequence
	property p_clk_hi;
		$rose(bus_clk) |-> s_hi;
	endproperty
	a_clk_hi: assert property (p_clk_hi) else $error("link clock high phase wrong");
	property p_clk_lo;
		$fell(bus_clk) |-> s_lo;
	endproperty
	a_clk_lo: assert property (p_clk_lo) else $error("link clock low phase short");
	property p_dev_bit;
		d_cmd_oe && $changed(d_cmd_out) |=> $stable(d_cmd_out) [*6];
	endproperty
	a_dev_bit: assert property (p_dev_bit) else $error("card command bit too short");
	property p_host_bit;
		h_cmd_oe && $changed(h_cmd_out) |=> $stable(h_cmd_out) [*6];
	endproperty
	a_host_bit: assert property (p_host_bit) else $error("host command bit too short");
	// ==========
	// Line ownership
	property p_cmd_one;
		!(h_cmd_oe && d_cmd_oe);
	endproperty
	a_cmd_one: assert property (p_cmd_one) else $error("both ends drive command line");
	property p_start;
		$rose(d_cmd_oe) |-> !d_cmd_out;
	endproperty
	a_start: assert property (p_start) else $error("card answer not started low");
	property p_dat_one;
		(h_dat_oe & d_dat_oe) == 8'h00;
	endproperty
	a_dat_one: assert property (p_dat_one) else $error("both ends drive a data line");
	property p_strobe;
		strobe |-> d_cmd_oe;
	endproperty
	a_strobe: assert property (p_strobe) else $error("strobe outside card answer");
	property p_hw_rst;
		(!rst_n) [*5] |-> !d_cmd_oe && d_dat_oe == 8'h00 && !strobe;
	endproperty
	a_hw_rst: assert property (p_hw_rst) else $error("card drives during hardware reset");
endmodule

/* File: verification/testbench.sv */
// Self-checking bench joining host controller and card over the card bus
`timescale 1ns/1ps
module testbench;
	localparam int PWR = 2000;
	localparam logic [31:0] SER = 32'h1357_9BDF;
	localparam logic [7:0] DATE = 8'h42;
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0;
	logic [1:0] htrans = 2'h0;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic hrdy;
	logic hresp;
	logic [31:0] hrdata;
	logic retire_stb = 1'b0;
	logic [2:0] retire_grp = 3'h0;
	logic [7:0] retired;
	logic pwr_done;
	logic seen_strb = 1'b0;
	logic [7:0] ret = 8'h00;
	logic [7:0] pon = 8'h00;
	logic [7:0] mem [16];
	integer bad_count = 0;
	integer compares = 0;
	integer seed = 70;
	logic [2:0] g;
	logic [2:0] pg;
	logic [31:0] s;
	card_bus_if bus();
	card_host card_host_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy), .hreadyout(hrdy), .hrdata(hrdata),
		.hresp(hresp), .bus(bus));
	card_device #(.PWRUP_CYC(PWR), .SERIAL(SER), .BUILD_DATE(DATE)) card_device_i (.hclk(hclk),
		.hresetn(hresetn), .bus(bus), .retire_stb(retire_stb), .retire_grp(retire_grp), .retired(retired),
		.pwr_done(pwr_done));
	card_bus_monitor mon_i (.hclk(hclk), .hresetn(hresetn), .bus_clk(bus.bus_clk), .rst_n(bus.rst_n),
		.strobe(bus.strobe), .h_cmd_out(bus.h_cmd_out), .h_cmd_oe(bus.h_cmd_oe), .d_cmd_out(bus.d_cmd_out),
		.d_cmd_oe(bus.d_cmd_oe), .h_dat_oe(bus.h_dat_oe), .d_dat_oe(bus.d_dat_oe));
	// ==========
	// Clock and shared tasks
	initial begin
		forever #50 hclk = ~hclk;
	end
	always @(posedge hclk) begin
		if (bus.strobe === 1'b1)
			seen_strb <= 1'b1;
	end
	task report_and_stop;
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task chk(input string name, input logic [127:0] seen, input logic [127:0] exp);
		compares++;
		if (seen !== exp) begin
			bad_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
		hsel <= 1'b1;
		haddr <= {24'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge hclk);
		while (hrdy !== 1'b1) @(posedge hclk);
		r = hrdata;
	endtask
	task op(input logic [7:0] o, input logic [31:0] a, input logic [7:0] wd, output logic [31:0] st);
		logic [31:0] r;
		integer n;
		ahb(1'b1, card_pkg::A_OP, {24'h0, o}, r);
		ahb(1'b1, card_pkg::A_ARG, a, r);
		ahb(1'b1, card_pkg::A_WDATA, {24'h0, wd}, r);
		ahb(1'b1, card_pkg::A_GO, 32'h0, r);
		n = 0;
		r = 32'h0;
		while (r[1] !== 1'b1 && n < 3000) begin
			ahb(1'b0, card_pkg::A_STATUS, 32'h0, r);
			n++;
		end
		chk("status done", r, 32'h2);
		ahb(1'b0, card_pkg::A_RESP0, 32'h0, st);
	endtask
	task access(input logic [3:0] a);
		logic [7:0] d;
		logic [31:0] st;
		logic p;
		d = 8'($random(seed));
		p = ret[a[3:1]] | pon[a[3:1]];
		op(card_pkg::OP_WRITE, {28'h0, a}, d, st);
		chk("write status", st, p ? 32'h1 : 32'h4);
		if (!p)
			mem[a] = d;
		op(card_pkg::OP_READ, {28'h0, a}, 8'h00, st);
		chk("read status", st, ret[a[3:1]] ? 32'h2 : 32'h4);
		ahb(1'b0, card_pkg::A_RDATA, 32'h0, st);
		if (!ret[a[3:1]])
			chk("read data", st, {24'h0, mem[a]});
		op(card_pkg::OP_PROT, {28'h0, a}, 8'h00, st);
		chk("protect", st, ret[a[3:1]] ? 32'h5 : (pon[a[3:1]] ? 32'h3 : 32'h0));
	endtask
	task condchk(input logic p);
		logic [31:0] r;
		op(card_pkg::OP_GET_COND, 32'h0, 8'h00, r);
		chk("condition", r, {p, 2'h2, 5'h00, 9'h1FF, 7'h00, 1'h1, 7'h00});
	endtask
	task idchk;
		logic [127:0] w;
		logic [127:0] e;
		logic [6:0] c;
		logic [31:0] r;
		e = {card_pkg::MAKER_CODE, 6'h00, 2'h1, card_pkg::APP_CODE, card_pkg::PRODUCT_LABEL,
			card_pkg::PRODUCT_REV, SER, DATE, 8'h01};
		c = 7'h00;
		for (int i = 127; i >= 8; i--) begin
			c = {c[5:0], 1'b0} ^ ((e[i] ^ c[6]) ? 7'h09 : 7'h00);
		end
		e[7:1] = c;
		op(card_pkg::OP_GET_ID, 32'h0, 8'h00, r);
		w[31:0] = r;
		ahb(1'b0, card_pkg::A_RESP1, 32'h0, r);
		w[63:32] = r;
		ahb(1'b0, card_pkg::A_RESP2, 32'h0, r);
		w[95:64] = r;
		ahb(1'b0, card_pkg::A_RESP3, 32'h0, r);
		w[127:96] = r;
		chk("identity", w, e);
	endtask
	// ==========
	// Main sequence and watchdog
	initial begin
		repeat (90000) @(posedge hclk);
		bad_count++;
		report_and_stop;
	end
	initial begin
		repeat (8) @(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		ahb(1'b0, card_pkg::A_STATUS, 32'h0, s);
		chk("status reset", s, 32'h0);
		ahb(1'b1, 8'h30, 32'hFFFF_FFFF, s);
		ahb(1'b0, 8'h30, 32'h0, s);
		chk("unmapped", s, 32'h0);
		chk("response", hresp, 1'b0);
		condchk(1'b0);
		chk("power done", pwr_done, 1'b0);
		idchk;
		for (int i = 0; i < 16; i++)
			access(4'(i));
		condchk(1'b1);
		chk("power done", pwr_done, 1'b1);
		g = 3'($random(seed));
		pg = g + 3'h4;
		retire_stb <= 1'b1;
		retire_grp <= g;
		@(posedge hclk);
		retire_stb <= 1'b0;
		ret[g] = 1'b1;
		repeat (2) @(posedge hclk);
		chk("retired", retired, ret);
		op(card_pkg::OP_PON_WP, {28'h0, pg, 1'b0}, 8'h00, s);
		pon[pg] = 1'b1;
		for (int i = 0; i < 16; i += 2)
			access(4'(i));
		ahb(1'b1, card_pkg::A_BUSCFG, 32'h2, s);
		repeat (10) @(posedge hclk);
		ahb(1'b1, card_pkg::A_BUSCFG, 32'h0, s);
		pon = 8'h00;
		repeat (10) @(posedge hclk);
		chk("power done", pwr_done, 1'b0);
		condchk(1'b0);
		access({g, 1'b0});
		access({pg, 1'b0});
		chk("retired", retired, ret);
		op(card_pkg::OP_SET_BUS, 32'h3, 8'h00, s);
		ahb(1'b1, card_pkg::A_BUSCFG, 32'h1, s);
		access({g + 3'h1, 1'b0});
		chk("strobe", seen_strb, 1'b1);
		idchk;
		report_and_stop;
	end
endmodule
